// [design/stc_pkg.sv]
/*
  package for the special and timed command parser: characters, codes, timing.
  assumes a 40 MHz system clock.
*/
package stc_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_BAR = 8'h7C;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [3:0] SP_HOLO = 4'h1;
  localparam logic [3:0] SP_CLR_DIS = 4'h8;
  localparam logic [3:0] SP_CLR_EN = 4'h9;
  localparam logic [2:0] UNIT_FRONT = 3'b001;
  localparam logic [2:0] UNIT_REAR = 3'b010;
  localparam logic [2:0] UNIT_TOP = 3'b100;
  localparam logic [2:0] UNIT_ALL = 3'b111;
  localparam logic [3:0] POS_DOWN = 4'h0;
  localparam logic [6:0] SEQ_HOLO = 7'h01;
  localparam logic [15:0] RUN_W = 16'h0000;
  localparam logic [15:0] RUN_MAX = 16'h1999;
  localparam logic TWITCH_RST = 1'b1;
  typedef enum logic [5:0] {
    STC_IDLE = 6'b000001,
    STC_TYPE = 6'b000010,
    STC_VAL1 = 6'b000100,
    STC_VAL2 = 6'b001000,
    STC_TAIL = 6'b010000,
    STC_SPEC = 6'b100000
  } stc_state_e;
endpackage

// [design/stc_parser.sv]
/*
  command parser: takes a byte stream, decodes regular, special and timed commands
  and issues one-cycle actions to the light and servo sequencers of three units.
  assumes bytes arrive as a one-cycle strobe on mclk; i2c framing gives end_in.
*/
// What this block does
// - hologram special: front unit down, flicker lights on, rear and top disabled.
// - clear-and-disable special: all lights off, both auto twitch modes off.
// - clear-and-enable special: all lights off, both auto twitch modes on.
// - a bar then decimal seconds after any command sets its run time.
// - on run-time expiry: halt, clear lights, restore prior twitch state.
// - one special command fires its light and servo actions together.
// - serial command ends at carriage return; i2c ends by framing instead.
// - first letter picks unit: front, rear, top or all three.
// - then type digit light or servo, then two-digit sequence value.
`timescale 1ns/10ps
module stc_parser
  import stc_pkg::*;
#(
  // cycles per second tick; only a bench that must see expiry shortens it
  parameter int unsigned TICK_N = TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic end_in,
  output logic cmd_go_ff,
  output logic [2:0] cmd_unit_ff,
  output logic cmd_servo_ff,
  output logic [6:0] cmd_seq_ff,
  output logic [3:0] cmd_arg_ff,
  output logic servo_go_ff,
  output logic [2:0] servo_unit_ff,
  output logic [3:0] servo_pos_ff,
  output logic [2:0] unit_dis_ff,
  output logic clear_go_ff,
  output logic [2:0] clear_unit_ff,
  output logic led_twitch_ff,
  output logic servo_twitch_ff,
  output logic timer_busy_ff,
  output logic bad_cmd_ff
);
  import stc_pkg::*;

  stc_state_e st_ff;
  logic [2:0] unit_ff;
  logic typ_ff;
  logic [6:0] seq_ff;
  logic [3:0] arg_ff;
  logic arg_seen_ff;
  logic bar_ff;
  logic [15:0] run_ff;
  logic err_ff;
  logic [25:0] pre_ff;
  logic [15:0] cnt_ff;
  logic tick;
  logic save_led_ff;
  logic save_servo_ff;
  logic [2:0] timed_unit_ff;
  logic is_digit;
  logic [3:0] dig;
  logic fin;
  logic expire;
  logic [2:0] unit_code;

  assign is_digit = (byte_data >= CH_0) && (byte_data <= CH_9);
  assign dig = 4'(byte_data - CH_0);
  // end of command: carriage return on serial, framing end on i2c
  assign fin = (byte_valid && byte_data == CH_CR) || end_in;

  always_comb begin
    unique case (byte_data)
      CH_F: unit_code = UNIT_FRONT;
      CH_R: unit_code = UNIT_REAR;
      CH_T: unit_code = UNIT_TOP;
      CH_A: unit_code = UNIT_ALL;
      default: unit_code = 3'b000;
    endcase
  end

  // character sequencer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= STC_IDLE;
      unit_ff <= 3'b000;
      typ_ff <= 1'b0;
      seq_ff <= 7'h00;
      arg_ff <= 4'h0;
      arg_seen_ff <= 1'b0;
      bar_ff <= 1'b0;
      run_ff <= RUN_W;
      err_ff <= 1'b0;
    end else if (fin) begin
      st_ff <= STC_IDLE;
      err_ff <= 1'b0;
      bar_ff <= 1'b0;
      run_ff <= RUN_W;
      arg_seen_ff <= 1'b0;
    end else if (byte_valid) begin
      unique case (st_ff)
        STC_IDLE: begin
          bar_ff <= 1'b0;
          run_ff <= RUN_W;
          arg_seen_ff <= 1'b0;
          arg_ff <= 4'h0;
          if (byte_data == CH_S) begin
            st_ff <= STC_SPEC;
            unit_ff <= UNIT_ALL;
          end else begin
            st_ff <= STC_TYPE;
            unit_ff <= unit_code;
            err_ff <= (unit_code == 3'b000);
          end
        end
        STC_TYPE: begin
          st_ff <= STC_VAL1;
          typ_ff <= (byte_data == 8'h31);
          if (byte_data != CH_0 && byte_data != 8'h31) begin
            err_ff <= 1'b1;
          end
        end
        STC_VAL1: begin
          st_ff <= STC_VAL2;
          seq_ff <= 7'(dig) * 7'd10; // leading digit kept
          if (!is_digit) begin
            err_ff <= 1'b1;
          end
        end
        STC_VAL2: begin
          st_ff <= STC_TAIL;
          seq_ff <= 7'(seq_ff + 7'(dig));
          if (!is_digit) begin
            err_ff <= 1'b1;
          end
        end
        STC_SPEC, STC_TAIL: begin
          if (byte_data == CH_BAR && !bar_ff) begin
            bar_ff <= 1'b1;
          end else if (bar_ff && is_digit) begin
            // saturate so long counts cannot wrap to short ones
            if (run_ff >= RUN_MAX) begin
              run_ff <= 16'hFFFF;
            end else begin
              run_ff <= 16'(run_ff * 16'd10 + 16'(dig));
            end
          end else if (!bar_ff && is_digit && !arg_seen_ff) begin
            arg_ff <= dig;
            arg_seen_ff <= 1'b1;
          end else begin
            err_ff <= 1'b1;
          end
        end
        default: st_ff <= STC_IDLE;
      endcase
    end
  end

  logic do_cmd;
  logic do_spec;
  logic load;
  assign do_cmd = fin && st_ff == STC_TAIL && !err_ff;
  assign do_spec = fin && st_ff == STC_SPEC && !err_ff && arg_seen_ff;
  assign load = (do_cmd || do_spec) && bar_ff && run_ff != 16'h0000;

  // one-second prescaler, only runs while a timed command is live
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pre_ff <= 26'h000_0000;
    end else if (!timer_busy_ff || pre_ff == 26'(TICK_N - 1)) begin
      pre_ff <= 26'h000_0000;
    end else begin
      pre_ff <= 26'(pre_ff + 26'd1);
    end
  end
  assign tick = timer_busy_ff && pre_ff == 26'(TICK_N - 1);
  assign expire = tick && cnt_ff == 16'h0001;

  // run-time counter and saved twitch state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 16'h0000;
      timer_busy_ff <= 1'b0;
      save_led_ff <= TWITCH_RST;
      save_servo_ff <= TWITCH_RST;
      timed_unit_ff <= 3'b000;
    end else if (load) begin
      cnt_ff <= run_ff;
      timer_busy_ff <= 1'b1;
      timed_unit_ff <= unit_ff;
      // a new timed command keeps the oldest auto state as the one to return to
      if (!timer_busy_ff) begin
        save_led_ff <= led_twitch_ff;
        save_servo_ff <= servo_twitch_ff;
      end
    end else if (expire) begin
      cnt_ff <= 16'h0000;
      timer_busy_ff <= 1'b0;
    end else if (tick) begin
      cnt_ff <= 16'(cnt_ff - 16'd1);
    end
  end

  // auto twitch enables; a twitch-setting or timed command in the expiry cycle wins over the restore
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      led_twitch_ff <= TWITCH_RST;
      servo_twitch_ff <= TWITCH_RST;
    end else if (do_spec && arg_ff == SP_CLR_DIS) begin
      led_twitch_ff <= 1'b0;
      servo_twitch_ff <= 1'b0;
    end else if (do_spec && arg_ff == SP_CLR_EN) begin
      led_twitch_ff <= 1'b1;
      servo_twitch_ff <= 1'b1;
    end else if (do_cmd && seq_ff == 7'd98) begin
      if (typ_ff) servo_twitch_ff <= 1'b0;
      else led_twitch_ff <= 1'b0;
    end else if (do_cmd && seq_ff == 7'd99) begin
      if (typ_ff) servo_twitch_ff <= 1'b1;
      else led_twitch_ff <= 1'b1;
    end else if (expire && !load) begin
      led_twitch_ff <= save_led_ff;
      servo_twitch_ff <= save_servo_ff;
    end
  end

  // action strobes; the hologram special drives light and servo in one cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_go_ff <= 1'b0;
      cmd_unit_ff <= 3'b000;
      cmd_servo_ff <= 1'b0;
      cmd_seq_ff <= 7'h00;
      cmd_arg_ff <= 4'h0;
      servo_go_ff <= 1'b0;
      servo_unit_ff <= 3'b000;
      servo_pos_ff <= 4'h0;
      unit_dis_ff <= 3'b000;
      clear_go_ff <= 1'b0;
      clear_unit_ff <= 3'b000;
      bad_cmd_ff <= 1'b0;
    end else begin
      cmd_go_ff <= 1'b0;
      servo_go_ff <= 1'b0;
      clear_go_ff <= 1'b0;
      bad_cmd_ff <= fin && st_ff != STC_IDLE && !do_cmd && !do_spec;
      if (do_cmd) begin
        cmd_go_ff <= 1'b1;
        cmd_unit_ff <= unit_ff;
        cmd_servo_ff <= typ_ff;
        cmd_seq_ff <= seq_ff;
        cmd_arg_ff <= arg_ff;
        unit_dis_ff <= unit_dis_ff & ~unit_ff;
      end else if (do_spec && arg_ff == SP_HOLO) begin
        cmd_go_ff <= 1'b1;
        cmd_unit_ff <= UNIT_FRONT;
        cmd_servo_ff <= 1'b0;
        cmd_seq_ff <= SEQ_HOLO;
        cmd_arg_ff <= 4'h0;
        servo_go_ff <= 1'b1;
        servo_unit_ff <= UNIT_FRONT;
        servo_pos_ff <= POS_DOWN;
        unit_dis_ff <= UNIT_REAR | UNIT_TOP;
      end else if (do_spec && (arg_ff == SP_CLR_DIS || arg_ff == SP_CLR_EN)) begin
        clear_go_ff <= 1'b1;
        clear_unit_ff <= UNIT_ALL;
        unit_dis_ff <= 3'b000;
      end else if (expire) begin
        clear_go_ff <= 1'b1;
        clear_unit_ff <= timed_unit_ff;
      end
    end
  end

  property p_holo;
    @(posedge mclk) disable iff (!reset_n)
      do_spec && arg_ff == SP_HOLO |=> cmd_go_ff && servo_go_ff && cmd_unit_ff == UNIT_FRONT
        && servo_pos_ff == POS_DOWN && unit_dis_ff == 3'b110;
  endproperty
  a_holo: assert property (p_holo) else $error("hologram mode wrong");
  property p_clr_dis;
    @(posedge mclk) disable iff (!reset_n)
      do_spec && arg_ff == SP_CLR_DIS |=> clear_go_ff && clear_unit_ff == UNIT_ALL
        && !led_twitch_ff && !servo_twitch_ff;
  endproperty
  a_clr_dis: assert property (p_clr_dis) else $error("clear-disable wrong");
  property p_clr_en;
    @(posedge mclk) disable iff (!reset_n)
      do_spec && arg_ff == SP_CLR_EN |=> clear_go_ff && led_twitch_ff && servo_twitch_ff;
  endproperty
  a_clr_en: assert property (p_clr_en) else $error("clear-enable wrong");
  property p_load;
    @(posedge mclk) disable iff (!reset_n)
      (do_cmd || do_spec) && bar_ff && run_ff != 16'h0000 |=> timer_busy_ff
        && cnt_ff == $past(run_ff);
  endproperty
  a_load: assert property (p_load) else $error("run time not loaded");
  property p_expire;
    @(posedge mclk) disable iff (!reset_n)
      expire && !(do_cmd || do_spec) |=> clear_go_ff && !timer_busy_ff
        && led_twitch_ff == $past(save_led_ff) && servo_twitch_ff == $past(save_servo_ff);
  endproperty
  a_expire: assert property (p_expire) else $error("expiry restore wrong");
  property p_tick;
    @(posedge mclk) disable iff (!reset_n)
      tick && cnt_ff > 16'h0001 && !(do_cmd || do_spec) |=> cnt_ff == $past(cnt_ff) - 16'd1;
  endproperty
  a_tick: assert property (p_tick) else $error("countdown wrong");
  property p_fin;
    @(posedge mclk) disable iff (!reset_n)
      fin |=> st_ff == STC_IDLE;
  endproperty
  a_fin: assert property (p_fin) else $error("terminator not honoured");
  property p_unit;
    @(posedge mclk) disable iff (!reset_n)
      byte_valid && !fin && st_ff == STC_IDLE && byte_data == CH_A
        |=> unit_ff == UNIT_ALL ##1 1'b1;
  endproperty
  a_unit: assert property (p_unit) else $error("unit decode wrong");
  property p_cmd;
    @(posedge mclk) disable iff (!reset_n)
      do_cmd |=> cmd_go_ff && cmd_seq_ff == $past(seq_ff) && cmd_servo_ff == $past(typ_ff);
  endproperty
  a_cmd: assert property (p_cmd) else $error("regular command wrong");
  property p_bad;
    @(posedge mclk) disable iff (!reset_n)
      fin && st_ff != STC_IDLE && err_ff |=> bad_cmd_ff && !cmd_go_ff && !servo_go_ff;
  endproperty
  a_bad: assert property (p_bad) else $error("malformed command not refused");
  c_holo: cover property (@(posedge mclk) disable iff (!reset_n) do_spec && arg_ff == SP_HOLO);
  c_timed: cover property (@(posedge mclk) disable iff (!reset_n) do_cmd && bar_ff);
  c_expire: cover property (@(posedge mclk) disable iff (!reset_n) expire);
  c_bad: cover property (@(posedge mclk) disable iff (!reset_n) bad_cmd_ff);
endmodule

// [bench/stc_host_model.sv]
/*
  host model for the command parser: sends ascii command strings as byte strobes.
  assumes the parser samples on the rising edge of mclk; drives 1 ns after it.
*/
`timescale 1ns/10ps
module stc_host_model
  import stc_pkg::*;
(
  input wire logic mclk,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic end_in
);
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    end_in = 1'b0;
  end

  // bytes back to back; idle data ends inverted after serial, back at the last byte after i2c
  task automatic send(input string s, input bit i2c);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge mclk) #1;
      byte_valid = 1'b1;
      byte_data = s[i];
    end
    @(posedge mclk) #1;
    if (i2c) begin
      byte_valid = 1'b0;
      byte_data = ~byte_data;
      end_in = 1'b1;
    end else begin
      byte_data = CH_CR;
    end
    @(posedge mclk) #1;
    byte_valid = 1'b0;
    end_in = 1'b0;
    byte_data = ~byte_data;
  endtask
endmodule

// [bench/special_and_timed_command_parser_tb_top.sv]
/*
  testbench for the command parser: host model drives bytes, an integer model
  predicts every action. assumes 40 MHz mclk; the second is shortened so expiry is seen.
*/
`timescale 1ns/10ps
module special_and_timed_command_parser_tb_top;
  import stc_pkg::*;
  logic mclk, reset_n, byte_valid, end_in;
  logic [7:0] byte_data;
  logic cmd_go_ff, cmd_servo_ff, servo_go_ff, clear_go_ff, led_twitch_ff;
  logic servo_twitch_ff, timer_busy_ff, bad_cmd_ff;
  logic [2:0] cmd_unit_ff, servo_unit_ff, unit_dis_ff, clear_unit_ff;
  logic [6:0] cmd_seq_ff;
  logic [3:0] cmd_arg_ff, servo_pos_ff;
  int num_errors = 0;
  int check_count = 0;
  int led_m = 1;
  int srv_m = 1;
  int dis_m = 0;
  string s;
  // cycles per second in the bench; a real second would not fit the run
  localparam int TB_TICK = 100;

  stc_parser #(.TICK_N(TB_TICK)) i_stc_parser(.mclk(mclk), .reset_n(reset_n),
    .byte_valid(byte_valid),
    .byte_data(byte_data), .end_in(end_in), .cmd_go_ff(cmd_go_ff),
    .cmd_unit_ff(cmd_unit_ff), .cmd_servo_ff(cmd_servo_ff), .cmd_seq_ff(cmd_seq_ff),
    .cmd_arg_ff(cmd_arg_ff), .servo_go_ff(servo_go_ff), .servo_unit_ff(servo_unit_ff),
    .servo_pos_ff(servo_pos_ff), .unit_dis_ff(unit_dis_ff), .clear_go_ff(clear_go_ff),
    .clear_unit_ff(clear_unit_ff), .led_twitch_ff(led_twitch_ff),
    .servo_twitch_ff(servo_twitch_ff), .timer_busy_ff(timer_busy_ff),
    .bad_cmd_ff(bad_cmd_ff));
  stc_host_model i_stc_host_model(.mclk(mclk), .byte_valid(byte_valid),
    .byte_data(byte_data), .end_in(end_in));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // bounded wait for a light or servo command, clear or refusal strobe; strobes stand one cycle
  task automatic wait_act();
    for (int i = 0; i < 4; i++) begin
      if ((cmd_go_ff | clear_go_ff | bad_cmd_ff) === 1'b1) return;
      @(posedge mclk) #2;
    end
    check(16'h0000, 16'h0001);
  endtask

  // timed command just issued: count edges to expiry, then check the restore
  task automatic wait_expire(input int secs);
    int n;
    n = 1;
    @(posedge mclk) #2;
    while (clear_go_ff !== 1'b1 && n < 4 * TB_TICK * secs) begin
      @(posedge mclk) #2;
      n++;
      if (n == TB_TICK) check(timer_busy_ff, 16'h0001);
    end
    check(16'(n), 16'(secs * TB_TICK));
    check({clear_go_ff, clear_unit_ff}, 16'h000f);
    check({timer_busy_ff, led_twitch_ff, servo_twitch_ff}, 16'(led_m * 2 + srv_m));
  endtask

  task automatic run_reg(input string c, input bit i2c);
    int u, sv, sq, ar;
    u = (c[0] == "F") ? 1 : (c[0] == "R") ? 2 : (c[0] == "T") ? 4 : 7;
    ar = (c.len() > 4) ? c[4] - 48 : 0;
    sv = c[1] - 48;
    sq = (c[2] - 48) * 10 + c[3] - 48;
    i_stc_host_model.send(c, i2c);
    if (sq >= 98) begin
      if (sv == 1) srv_m = sq - 98;
      else led_m = sq - 98;
      repeat (3) @(posedge mclk) #2;
      check(led_twitch_ff, 16'(led_m));
      check(servo_twitch_ff, 16'(srv_m));
    end else begin
      dis_m &= ~u;
      wait_act();
      check(cmd_go_ff, 16'h0001);
      check(cmd_unit_ff, 16'(u));
      check(cmd_servo_ff, 16'(sv));
      check(cmd_seq_ff, 16'(sq));
      check(cmd_arg_ff, 16'(ar));
      check(unit_dis_ff, 16'(dis_m));
    end
    $display("test %s done", c);
  endtask

  initial begin
    reset_n = 1'b0;
    void'($urandom(32'hf48d0894));
    repeat (3) @(posedge mclk);
    #1 reset_n = 1'b1;
    check(led_twitch_ff, 16'(TWITCH_RST));
    check(timer_busy_ff, 16'h0000);
    i_stc_host_model.send("S1", 1'b0);
    wait_act();
    check({servo_go_ff, cmd_go_ff}, 16'h0003);
    check({cmd_servo_ff, cmd_unit_ff}, 16'h0001);
    check(cmd_seq_ff, 16'(SEQ_HOLO));
    check({servo_unit_ff, servo_pos_ff}, {9'h000, 3'b001, POS_DOWN});
    check(unit_dis_ff, 16'h0006);
    dis_m = 6;
    $display("test hologram done");
    for (int i = 0; i < 8; i++) begin
      s = $sformatf("%s%0d%02d%0d", i[1:0] == 0 ? "F" : i[1:0] == 1 ? "R" : i[1:0] == 2 ?
        "T" : "A", $urandom_range(0, 1), $urandom_range(1, 97), $urandom_range(0, 9));
      run_reg(s, i[2]);
    end
    // second pass shows the enable really re-arms both twitch modes
    for (int k = 0; k < 2; k++) begin
      i_stc_host_model.send(k ? "S9" : "S8", k[0]);
      wait_act();
      led_m = k;
      srv_m = k;
      check({clear_go_ff, clear_unit_ff}, 16'h000f);
      check({led_twitch_ff, servo_twitch_ff}, k ? 16'h0003 : 16'h0000);
      check(unit_dis_ff, 16'h0000);
      $display("test clear %0d done", k);
    end
    dis_m = 0;
    run_reg("A098", 1'b0);
    run_reg("T198", 1'b1);
    i_stc_host_model.send("X007", 1'b0);
    wait_act();
    check({bad_cmd_ff, cmd_go_ff}, 16'h0002);
    i_stc_host_model.send("F207", 1'b1);
    wait_act();
    check({bad_cmd_ff, cmd_go_ff}, 16'h0002);
    $display("test malformed done");
    i_stc_host_model.send("F006|0", 1'b0);
    wait_act();
    check({cmd_go_ff, timer_busy_ff}, 16'h0002);
    i_stc_host_model.send("A007|3", 1'b1);
    wait_act();
    check({cmd_go_ff, timer_busy_ff}, 16'h0003);
    check(cmd_seq_ff, 16'h0007);
    wait_expire(3);
    // timed clear-and-enable: auto modes on, then back to the state before it
    i_stc_host_model.send("S9|2", 1'b0);
    wait_act();
    check({clear_go_ff, timer_busy_ff, led_twitch_ff, servo_twitch_ff}, 16'h000f);
    wait_expire(2);
    $display("test timed done");
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    wrap_up();
  end
endmodule
